// ---- logic/gbr_pkg.sv ----
package gbr_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the axi4-lite slave)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_LOCAL_WINDOW = 8'h00;
  localparam logic [7:0] ADDR_MP_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int BASE_LSB = 0;
  localparam int MATCH_LSB = 4;
  localparam int MP_EN_BIT = 0;
  localparam int ADDR_CMP_LSB = 20;
  localparam logic [7:0] LOCAL_WINDOW_RESET = 8'h00;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_DECERR = 2'h3;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [23:0] addr;
    logic locked;
  } gbr_req_s;

endpackage

// ---- logic/gbr_sync.sv ----
`timescale 1ns/1ns
module gbr_sync
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic d_in,
  output logic q_out
);
  logic meta_q;

  // both stages reset high: the synchronised pins are active low
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta_q <= 1'b1;
      q_out <= 1'b1;
    end
    else
    begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end
endmodule

// ---- logic/gbr_top.sv ----
// What this block does
// R01 - multiprocessor mode only when software sets enable after programming window compare
// R02 - in this mode timer bidir pin is global request, timer input is global grant
// R03 - compare address bits 20..23 against the 4-bit base before each external access
// R04 - all compared bits equal means local bus; any mismatch requests global bus
// R05 - base one needs address one, base zero needs address zero
// R06 - cleared match-enable bit always matches; all cleared means always local
// R07 - on local request, float control outputs including global request, then grant
// R08 - after reset, honour a pending local request before any own access
// R09 - drive global address and status first, assert global request mid-cycle
// R10 - synchronise request and grant; start global access on grant without local request
// R11 - keep global bus for consecutive accesses; release on local, request, or grant loss
// R12 - locked read-write pairs and burst transfers finish before global release; here only the locked flag holds the bus, bursts are not tracked
// R13 - dma addresses use the same compare and the same global handshake
// R14 - arbiter drives grant low to give the bus, high to withdraw it
// R15 - local requester holds its request low while seeking or owning the bus
// R16 - global request deasserts when the global bus is released
`timescale 1ns/1ns
module gbr_top
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // access requests from the cpu core and the dma channels
  input wire gbr_pkg::gbr_req_s cpu_req_in,
  output logic cpu_go_out,
  output logic cpu_global_out,
  input wire gbr_pkg::gbr_req_s dma_req_in,
  output logic dma_go_out,
  output logic dma_global_out,
  input wire logic access_done_in,
  // bus clock half-cycle enables
  input wire logic bus_rise_en_in,
  input wire logic bus_fall_en_in,
  // pins
  input wire logic local_bus_request_n_in,
  output logic local_bus_grant_n_out,
  output logic bus_ctrl_oe_out,
  output logic timer_bidir_pin_out,
  output logic timer_bidir_pin_oe_out,
  input wire logic timer_bidir_pin_in,
  input wire logic timer_input_pin_in,
  input wire logic timer_io_value_in,
  input wire logic timer_io_oe_in,
  output logic timer_input_to_ctr_out,
  output logic [23:0] addr_out
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_s1_q;
  logic rst_n;

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // registers over axi4-lite
  // ----------------------------------------------------------------
  logic [7:0] local_window_compare_q;
  logic multiprocessor_enable_q;
  logic aw_got_q;
  logic w_got_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_write;
  logic [31:0] status_word;

  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready = !w_got_q && !s_axi_bvalid;
  assign do_write = aw_got_q && w_got_q && !s_axi_bvalid;

  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= gbr_pkg::AXI_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_q == gbr_pkg::ADDR_LOCAL_WINDOW || aw_addr_q == gbr_pkg::ADDR_MP_CONTROL ||
                        aw_addr_q == gbr_pkg::ADDR_STATUS) ? gbr_pkg::AXI_OKAY : gbr_pkg::AXI_DECERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // only byte lane 0 carries register bits
  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      local_window_compare_q <= gbr_pkg::LOCAL_WINDOW_RESET;
      multiprocessor_enable_q <= 1'b0;
    end
    else if (do_write && w_strb_q[0])
    begin
      if (aw_addr_q == gbr_pkg::ADDR_LOCAL_WINDOW)
      begin
        local_window_compare_q <= w_data_q[7:0];
      end
      if (aw_addr_q == gbr_pkg::ADDR_MP_CONTROL)
      begin
        multiprocessor_enable_q <= w_data_q[gbr_pkg::MP_EN_BIT]; // [R01]
      end
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= gbr_pkg::AXI_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= gbr_pkg::AXI_OKAY;
      unique case (s_axi_araddr)
        gbr_pkg::ADDR_LOCAL_WINDOW: s_axi_rdata <= {24'h000000, local_window_compare_q};
        gbr_pkg::ADDR_MP_CONTROL: s_axi_rdata <= {31'h00000000, multiprocessor_enable_q};
        gbr_pkg::ADDR_STATUS: s_axi_rdata <= status_word;
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= gbr_pkg::AXI_DECERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pin reuse and synchronisers
  // ----------------------------------------------------------------
  logic req_n_sync;
  logic grant_n_sync;
  logic global_request_out;

  gbr_sync u_sync_req
  (
    .clk_in(mclk_in),
    .rst_n_in(rst_n),
    .d_in(local_bus_request_n_in),
    .q_out(req_n_sync)
  );

  // grant pin is only meaningful in multiprocessor mode
  gbr_sync u_sync_grant
  (
    .clk_in(mclk_in),
    .rst_n_in(rst_n),
    .d_in(multiprocessor_enable_q ? timer_input_pin_in : 1'b1), // [R02] [R14]
    .q_out(grant_n_sync)
  );

  logic local_req;
  logic global_grant_in;
  assign local_req = !req_n_sync; // [R10] [R15]
  assign global_grant_in = !grant_n_sync; // [R10]

  // timer keeps its pins unless multiprocessor mode takes them over
  assign timer_input_to_ctr_out = multiprocessor_enable_q ? 1'b0 : timer_input_pin_in;

  // ----------------------------------------------------------------
  // window compare
  // ----------------------------------------------------------------
  function automatic logic is_global(input logic [23:0] a, input logic [7:0] w, input logic mp);
    logic [3:0] hi;
    logic [3:0] base;
    logic [3:0] en;
    hi = a[gbr_pkg::ADDR_CMP_LSB +: 4]; // [R03]
    base = w[gbr_pkg::BASE_LSB +: 4];
    en = w[gbr_pkg::MATCH_LSB +: 4];
    // disabled positions always match, so en==0 is always local
    return mp && (|((hi ^ base) & en)); // [R04] [R05] [R06]
  endfunction

  // ----------------------------------------------------------------
  // arbitration between cpu and dma, ownership state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {ST_BOOT, ST_BOOT_WAIT, ST_BOOT_CHECK, ST_IDLE, ST_LOCAL, ST_GLOBAL_REQUEST_OUT_SETUP, ST_GLOBAL_REQUEST_OUT_WAIT,
                            ST_GLOBAL, ST_YIELD, ST_YIELDED} gbr_state_e;
  gbr_state_e state_q;
  gbr_state_e state_d;
  logic sel_dma_q;
  logic locked_q;
  logic global_held_q;
  logic global_request_out_q;
  logic [23:0] addr_q;

  gbr_pkg::gbr_req_s pick;
  logic pick_dma;
  logic pick_global;
  assign pick_dma = dma_req_in.valid;
  assign pick = pick_dma ? dma_req_in : cpu_req_in;
  assign pick_global = is_global(pick.addr, local_window_compare_q, multiprocessor_enable_q); // [R13]

  logic release_global;
  // a locked pair keeps the global bus despite request or grant loss
  assign release_global = global_held_q && !locked_q &&
                          (local_req || !global_grant_in || (pick.valid && !pick_global)); // [R11] [R12]

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      // two waiting steps let the request synchroniser show the pin before the first decision
      ST_BOOT: state_d = ST_BOOT_WAIT;
      ST_BOOT_WAIT: state_d = ST_BOOT_CHECK;
      ST_BOOT_CHECK: state_d = local_req ? ST_YIELD : ST_IDLE; // [R08]
      ST_IDLE:
      begin
        if (local_req && !global_held_q)
          state_d = ST_YIELD; // [R07]
        else if (release_global)
          state_d = ST_IDLE;
        else if (pick.valid && pick_global)
          state_d = global_held_q ? ST_GLOBAL : (bus_rise_en_in ? ST_GLOBAL_REQUEST_OUT_SETUP : ST_IDLE); // [R09] [R11]
        else if (pick.valid)
          state_d = ST_LOCAL;
      end
      ST_LOCAL: if (access_done_in) state_d = ST_IDLE;
      ST_GLOBAL_REQUEST_OUT_SETUP: if (bus_fall_en_in) state_d = ST_GLOBAL_REQUEST_OUT_WAIT; // [R09]
      ST_GLOBAL_REQUEST_OUT_WAIT:
      begin
        if (global_grant_in && !local_req)
          state_d = ST_GLOBAL; // [R10]
        else if (local_req)
          state_d = ST_YIELD;
      end
      ST_GLOBAL: if (access_done_in) state_d = ST_IDLE;
      ST_YIELD: state_d = ST_YIELDED; // [R07]
      ST_YIELDED: if (!local_req) state_d = ST_IDLE;
      default: state_d = ST_BOOT;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= ST_BOOT;
    else
      state_q <= state_d;
  end

  // request is latched when the access is chosen
  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_dma_q <= 1'b0;
      locked_q <= 1'b0;
      addr_q <= 24'h000000;
    end
    else if (state_q == ST_IDLE && state_d != ST_IDLE && state_d != ST_YIELD)
    begin
      sel_dma_q <= pick_dma;
      locked_q <= pick.locked; // [R12]
      addr_q <= pick.addr; // [R09]
    end
  end

  // global ownership and request pin
  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      global_held_q <= 1'b0;
      global_request_out_q <= 1'b0;
    end
    else
    begin
      if (state_q == ST_GLOBAL_REQUEST_OUT_WAIT && state_d == ST_GLOBAL)
        global_held_q <= 1'b1;
      else if (state_q == ST_IDLE && release_global)
        global_held_q <= 1'b0;
      if (state_q == ST_GLOBAL_REQUEST_OUT_SETUP && bus_fall_en_in)
        global_request_out_q <= 1'b1; // [R09]
      else if ((state_q == ST_IDLE && release_global) || state_d == ST_YIELD || state_q == ST_YIELD)
        global_request_out_q <= 1'b0; // [R16]
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic yielding;
  assign yielding = state_q inside {ST_BOOT, ST_BOOT_WAIT, ST_BOOT_CHECK, ST_YIELD, ST_YIELDED};
  assign global_request_out = global_request_out_q;

  // controls float first; grant follows one cycle later
  assign bus_ctrl_oe_out = !yielding; // [R07]
  assign local_bus_grant_n_out = !(state_q == ST_YIELDED); // [R07]

  assign timer_bidir_pin_out = multiprocessor_enable_q ? !global_request_out : timer_io_value_in; // [R02]
  assign timer_bidir_pin_oe_out = multiprocessor_enable_q ? !yielding : timer_io_oe_in; // [R07]

  assign cpu_go_out = (state_q == ST_LOCAL || state_q == ST_GLOBAL) && !sel_dma_q;
  assign dma_go_out = (state_q == ST_LOCAL || state_q == ST_GLOBAL) && sel_dma_q; // [R13]
  assign cpu_global_out = (state_q == ST_GLOBAL) && !sel_dma_q;
  assign dma_global_out = (state_q == ST_GLOBAL) && sel_dma_q;
  assign addr_out = addr_q;

  assign status_word = {24'h000000, timer_bidir_pin_in, state_q == ST_YIELDED, global_held_q, global_request_out_q,
                        global_grant_in, local_req, state_q == ST_GLOBAL, state_q == ST_LOCAL};

endmodule

// ---- sim/gbr_far_end.sv ----
`timescale 1ns/1ns
module gbr_far_end
(
  input wire logic clk_in,
  input wire logic global_request_out_pin_in,
  input wire logic withdraw_in,
  input wire logic slow_in,
  input wire logic want_bus_in,
  output logic grant_n_out = 1'b1,
  output logic bus_req_n_out = 1'b1
);
  logic [2:0] wait_q = 3'h0;
  // a floated request line reads high through its pull-up
  always_ff @(posedge clk_in)
  begin
    if (global_request_out_pin_in || withdraw_in)
    begin
      wait_q <= 3'h0;
      grant_n_out <= 1'b1;
    end
    else if (wait_q == (slow_in ? 3'h5 : 3'h0))
      grant_n_out <= 1'b0;
    else
      wait_q <= wait_q + 3'h1;
  end
  // held low all the while the requester seeks or owns the bus
  always_ff @(posedge clk_in)
    bus_req_n_out <= !want_bus_in;
endmodule

// ---- sim/gbr_props.sv ----
`timescale 1ns/1ns
module gbr_props
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_arready,
  input wire logic cpu_go_out,
  input wire logic cpu_global_out,
  input wire logic dma_go_out,
  input wire logic access_done_in,
  input wire logic bus_fall_en_in,
  input wire logic local_bus_request_n_in,
  input wire logic local_bus_grant_n_out,
  input wire logic bus_ctrl_oe_out,
  input wire logic timer_bidir_pin_out,
  input wire logic timer_bidir_pin_oe_out,
  input wire logic timer_input_pin_in
);
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence s_go_ends;
    cpu_go_out ##1 !cpu_go_out;
  endsequence
  sequence s_global_start;
    $rose(cpu_go_out) && cpu_global_out;
  endsequence
  chk_go_till_done: assert property (s_go_ends |-> $past(access_done_in))
    else $error("access ended without done");
  chk_float_first: assert property ($fell(local_bus_grant_n_out) |-> !$past(bus_ctrl_oe_out))
    else $error("grant before controls floated");
  chk_yield_floats: assert property (!local_bus_grant_n_out |-> !bus_ctrl_oe_out && !timer_bidir_pin_oe_out)
    else $error("driving while yielded");
  chk_grant_needs_req: assert property ($fell(local_bus_grant_n_out) |-> !$past(local_bus_request_n_in, 2))
    else $error("grant without request");
  chk_yield_no_go: assert property (!local_bus_grant_n_out |-> !cpu_go_out && !dma_go_out)
    else $error("access while yielded");
  chk_global_on_grant: assert property (s_global_start |-> !$past(timer_input_pin_in, 2))
    else $error("global access without grant");
  chk_global_request_out_mid_cycle: assert property ($fell(timer_bidir_pin_out) && timer_bidir_pin_oe_out |-> $past(bus_fall_en_in))
    else $error("global request off mid cycle");
  chk_local_no_global_request_out: assert property (cpu_go_out && !cpu_global_out && timer_bidir_pin_oe_out |-> timer_bidir_pin_out)
    else $error("global request during local access");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read taken without an answer");
endmodule
bind gbr_top gbr_props i_props (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_arready(s_axi_arready), .cpu_go_out(cpu_go_out), .cpu_global_out(cpu_global_out),
  .dma_go_out(dma_go_out), .access_done_in(access_done_in), .bus_fall_en_in(bus_fall_en_in),
  .local_bus_request_n_in(local_bus_request_n_in), .local_bus_grant_n_out(local_bus_grant_n_out),
  .bus_ctrl_oe_out(bus_ctrl_oe_out), .timer_bidir_pin_out(timer_bidir_pin_out),
  .timer_bidir_pin_oe_out(timer_bidir_pin_oe_out), .timer_input_pin_in(timer_input_pin_in));

// ---- sim/gbr_top_tb.sv ----
`timescale 1ns/1ns
module gbr_top_tb;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, win = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, cpu_go, cpu_glb, dma_go, dma_glb, gnt_n, ctl_oe, pin, pin_oe;
  logic [1:0] bresp, rresp, phase = 2'h0;
  logic done = 1'b0, rise_en = 1'b0, fall_en = 1'b0, withdraw = 1'b0, slow = 1'b0, want = 1'b1, mp = 1'b0;
  logic global_grant_in_n, breq_n, ctr_in;
  logic [23:0] addr;
  gbr_pkg::gbr_req_s cpu_req = '{valid: 1'b1, addr: 24'h0, locked: 1'b0}, dma_req = '0;
  wire logic pin_lvl = pin_oe ? pin : 1'b1;
  int fail_count = 0, checks = 0, cyc = 0;
  gbr_top i_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cpu_req_in(cpu_req),
    .cpu_go_out(cpu_go), .cpu_global_out(cpu_glb), .dma_req_in(dma_req), .dma_go_out(dma_go),
    .dma_global_out(dma_glb), .access_done_in(done), .bus_rise_en_in(rise_en), .bus_fall_en_in(fall_en),
    .local_bus_request_n_in(breq_n), .local_bus_grant_n_out(gnt_n), .bus_ctrl_oe_out(ctl_oe),
    .timer_bidir_pin_out(pin), .timer_bidir_pin_oe_out(pin_oe), .timer_bidir_pin_in(pin_lvl),
    .timer_input_pin_in(global_grant_in_n), .timer_io_value_in(1'b1), .timer_io_oe_in(1'b0),
    .timer_input_to_ctr_out(ctr_in), .addr_out(addr));
  gbr_far_end i_far (.clk_in(mclk_in), .global_request_out_pin_in(pin_lvl), .withdraw_in(withdraw), .slow_in(slow),
    .want_bus_in(want), .grant_n_out(global_grant_in_n), .bus_req_n_out(breq_n));
  initial
    forever #5 mclk_in = ~mclk_in;
  // bus clock of four processor clocks, mid-cycle enable two after start
  always @(posedge mclk_in)
  begin
    phase <= phase + 2'h1;
    rise_en <= phase == 2'h3;
    fall_en <= phase == 2'h1;
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      fail_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  // ----------------------------------------------------------------
  // bus tasks; ready is sampled at the falling edge, acted on at the rising one
  // ----------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_t, w_t;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(negedge mclk_in);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      @(posedge mclk_in);
      if (aw_t)
        awvalid <= 1'b0;
      if (w_t)
        wvalid <= 1'b0;
    end while ((awvalid && !aw_t) || (wvalid && !w_t));
    do
      @(negedge mclk_in);
    while (!bvalid);
    check("bresp", 32'(bresp), 32'(er));
    @(posedge mclk_in);
    bready <= 1'b0;
    // one spare edge so a following call never assigns the same strobe in this time step
    @(posedge mclk_in);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic t;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge mclk_in);
      t = arready;
      @(posedge mclk_in);
    end while (!t);
    arvalid <= 1'b0;
    do
      @(negedge mclk_in);
    while (!rvalid);
    check("rdata", rdata, ed);
    check("rresp", 32'(rresp), 32'(er));
    @(posedge mclk_in);
    rready <= 1'b0;
    @(posedge mclk_in);
  endtask
  function automatic logic exp_glb(input logic [23:0] a);
    return mp && (|((a[23:20] ^ win[3:0]) & win[7:4]));
  endfunction
  task automatic access(input logic dma, input logic [23:0] a, input logic lk);
    gbr_pkg::gbr_req_s r;
    r = '{valid: 1'b1, addr: a, locked: lk};
    if (dma)
      dma_req <= r;
    else
      cpu_req <= r;
    do
      @(negedge mclk_in);
    while (!(dma ? dma_go : cpu_go));
    check("global", 32'(dma ? dma_glb : cpu_glb), 32'(exp_glb(a)));
    check("address", 32'(addr), 32'(a));
    @(posedge mclk_in);
    cpu_req <= '0;
    dma_req <= '0;
    done <= 1'b1;
    @(posedge mclk_in);
    done <= 1'b0;
  endtask
  task automatic set_win(input logic [7:0] w);
    win = w;
    axi_wr(gbr_pkg::ADDR_LOCAL_WINDOW, 32'(w), gbr_pkg::AXI_OKAY);
  endtask
  initial
  begin
    void'($urandom(27));
    repeat (8) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (8) @(posedge mclk_in);
    check("grant at reset", 32'(gnt_n), 32'h0);
    want <= 1'b0;
    access(1'b0, 24'h0, 1'b0);
    axi_rd(gbr_pkg::ADDR_LOCAL_WINDOW, 32'(gbr_pkg::LOCAL_WINDOW_RESET), gbr_pkg::AXI_OKAY);
    axi_rd(8'h0c, 32'h0, gbr_pkg::AXI_DECERR);
    axi_wr(8'h0c, 32'h0, gbr_pkg::AXI_DECERR);
    set_win(8'hf5);
    axi_rd(gbr_pkg::ADDR_LOCAL_WINDOW, 32'hf5, gbr_pkg::AXI_OKAY);
    access(1'b0, 24'ha00000, 1'b0);
    check("timer input forwarded", 32'(ctr_in), 32'(global_grant_in_n));
    mp = 1'b1;
    axi_wr(gbr_pkg::ADDR_MP_CONTROL, 32'h1, gbr_pkg::AXI_OKAY);
    axi_rd(gbr_pkg::ADDR_MP_CONTROL, 32'h1, gbr_pkg::AXI_OKAY);
    // idle, nothing held, request pin driven high with no global request out: only bit 7 set
    axi_rd(gbr_pkg::ADDR_STATUS, 32'h80, gbr_pkg::AXI_OKAY);
    @(negedge mclk_in);
    check("request pin driven", 32'(pin_oe), 32'h1);
    check("timer input taken", 32'(ctr_in), 32'h0);
    for (int i = 0; i < 24; i++)
    begin
      if (i % 6 == 0)
        set_win(i == 12 ? 8'h0f : 8'($urandom));
      slow <= 1'($urandom);
      access(1'($urandom), 24'($urandom), 1'b0);
    end
    set_win(8'hf0);
    access(1'b0, 24'h800000, 1'b1);
    withdraw <= 1'b1;
    repeat (8) @(posedge mclk_in);
    check("locked hold", 32'(pin_lvl), 32'h0);
    withdraw <= 1'b0;
    // let the arbiter grant again before the second half of the locked pair
    repeat (8) @(posedge mclk_in);
    access(1'b0, 24'h800000, 1'b0);
    access(1'b1, 24'h900000, 1'b0);
    withdraw <= 1'b1;
    repeat (8) @(posedge mclk_in);
    check("release on loss", 32'(pin_lvl), 32'h1);
    withdraw <= 1'b0;
    access(1'b0, 24'h800000, 1'b0);
    want <= 1'b1;
    do
      @(negedge mclk_in);
    while (gnt_n);
    check("floated on yield", 32'(pin_oe), 32'h0);
    @(posedge mclk_in);
    want <= 1'b0;
    access(1'b0, 24'h100000, 1'b0);
    end_sim();
  end
endmodule
